// [rtl/tsic_pkg.sv]
// Constants, field positions and carrier types for the three-source interrupt control block
// Overview of operation
// - Exactly three request sources exist: the external pin, the timer overflow, and a change on four upper port pins.
// - The global enable at bit 7 of the control register lets unmasked requests through when set and blocks all when clear.
// - Each source has its own enable bit in the control register, and a clear enable stops that source from vectoring.
// - Every reset clears the global enable, so nothing is taken until software sets it again.
// - The three request flags live in the control register and record each request separately.
// - A request flag is set by its event whatever its own enable and the global enable hold.
// - Taking an interrupt clears the global enable, pushes the return address and loads the program counter with 0004h.
// - From an external pin or port change event the vector follows after three or four instruction cycles.
// - Request flags never clear themselves and stay set until software clears them.
// - The return-from-interrupt operation leaves the routine and sets the global enable again in the same step.
// - When an instruction clears the global enable, the next cycle runs a no-operation and ignored requests stay pending.
// - Return addresses go onto an 8-level 13-bit circular stack where a ninth push overwrites the oldest entry, with no overflow flag.
// - Return-from-interrupt pops the top entry into the program counter and leaves the upper counter latch alone.
// - The timer overflow flag is set when the 8-bit timer wraps from FFh to 00h.
package tsic_pkg;

  // Byte addresses of the register words
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_TMR  = 32'h0000_0004;
  localparam logic [31:0] ADDR_STAT = 32'h0000_0008;

  // Control register field positions
  localparam int GIE_BIT = 7;
  localparam int TIE_BIT = 5;
  localparam int XIE_BIT = 4;
  localparam int CIE_BIT = 3;
  localparam int TIF_BIT = 2;
  localparam int XIF_BIT = 1;
  localparam int CIF_BIT = 0;

  // Reset values and masks
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK  = 8'hBF;
  localparam logic [7:0] TMR_RESET  = 8'h00;
  localparam logic [7:0] TMR_MAX    = 8'hFF;

  // Core-facing widths and constants
  localparam int          PC_W        = 13;
  localparam int          STACK_DEPTH = 8;
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;

  // Timing: one instruction cycle is four clocks
  localparam logic [1:0] ICYC_LAST   = 2'h3;
  localparam logic [1:0] LAT_TAKE    = 2'h2;
  localparam logic [1:0] TMR_INHIBIT = 2'h2;
  localparam logic [2:0] HSIZE_WORD  = 3'h2;

  // Requests from the core sequencer
  typedef struct packed {
    logic        push;
    logic        pop;
    logic        ret_irq;
    logic        gie_clr;
    logic [12:0] pc;
  } tsic_core_req_t;

  // Answers to the core sequencer
  typedef struct packed {
    logic        vec_take;
    logic        no_operation;
    logic        pc_load;
    logic [12:0] pc_val;
  } tsic_core_resp_t;

endpackage : tsic_pkg

// [rtl/tsic_top.sv]
// Three-source interrupt control with AHB-Lite register slave, timer and return stack
`timescale 1ns/100ps
`default_nettype none

module tsic_top (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  input  wire logic                     ext_irq_pin,
  input  wire logic [3:0]               change_watch_pins,
  input  wire logic                     upper_port_read,
  input  wire tsic_pkg::tsic_core_req_t core_req,
  output tsic_pkg::tsic_core_resp_t     core_resp,
  output logic                          icyc_tick
);

  // Depth alias, declared ahead of the storage that is sized by it
  localparam int STACK_DEPTH_L = tsic_pkg::STACK_DEPTH;

  logic [1:0]  div_r;
  logic        icyc_r;
  logic        ext_s1_r, ext_s2_r, ext_s3_r;
  logic [3:0]  chg_s1_r, chg_s2_r, port_latch_r;
  logic [7:0]  ctrl_r;
  logic [7:0]  tmr_r;
  logic [1:0]  tmr_hold_r;
  logic [1:0]  lat_r;
  logic        supp_r;
  logic [12:0] stack_r [STACK_DEPTH_L];
  logic [2:0]  sp_r;
  logic        wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] hrdata_r;
  tsic_pkg::tsic_core_resp_t resp_r;

  // Wrapping stack index arithmetic, shared by push and pop
  function automatic logic [2:0] stk_step(input logic [2:0] sp, input logic up);
    stk_step = up ? 3'(sp + 3'h1) : 3'(sp - 3'h1);
  endfunction : stk_step

  // Instruction-cycle divider: one enable pulse every four clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r  <= 2'h0;
      icyc_r <= 1'b0;
    end else begin
      div_r  <= 2'(div_r + 2'h1);
      icyc_r <= (div_r == tsic_pkg::ICYC_LAST);
    end
  end
  assign icyc_tick = icyc_r;

  // Two-flop synchronisers, third stage feeds edge detection only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      chg_s1_r <= 4'h0;
      chg_s2_r <= 4'h0;
    end else begin
      ext_s1_r <= ext_irq_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      chg_s1_r <= change_watch_pins;
      chg_s2_r <= chg_s1_r;
    end
  end

  // Port value seen by the last read of the upper port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_latch_r <= 4'h0;
    end else if (upper_port_read) begin
      port_latch_r <= chg_s2_r;
    end
  end

  // Source events; rising edge on the pin
  logic ext_evt, chg_evt, tmr_evt;
  assign ext_evt = ext_s2_r & ~ext_s3_r;
  assign chg_evt = (chg_s2_r != port_latch_r);
  assign tmr_evt = icyc_r & (tmr_hold_r == 2'h0) & (tmr_r == tsic_pkg::TMR_MAX)
                   & ~(wr_pend_r & (wr_addr_r == tsic_pkg::ADDR_TMR));

  // Bus write decode in the data phase, word size only
  logic wr_ctrl, wr_tmr;
  assign wr_ctrl = wr_pend_r & (wr_addr_r == tsic_pkg::ADDR_CTRL);
  assign wr_tmr  = wr_pend_r & (wr_addr_r == tsic_pkg::ADDR_TMR);

  // Timer: steps once per instruction cycle, a write holds it off two cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_r      <= tsic_pkg::TMR_RESET;
      tmr_hold_r <= 2'h0;
    end else if (wr_tmr) begin
      tmr_r      <= hwdata[7:0];
      tmr_hold_r <= tsic_pkg::TMR_INHIBIT;
    end else if (icyc_r) begin
      if (tmr_hold_r != 2'h0) begin
        tmr_hold_r <= 2'(tmr_hold_r - 2'h1);
      end else begin
        tmr_r <= 8'(tmr_r + 8'h01);   // FFh wraps to 00h
      end
    end
  end

  // Pending request: flag and own enable, gated by the global enable
  logic [2:0] flags, enables;
  logic       pend, take, pop_req, push_req;
  assign flags   = {ctrl_r[tsic_pkg::TIF_BIT], ctrl_r[tsic_pkg::XIF_BIT],
                    ctrl_r[tsic_pkg::CIF_BIT]};
  assign enables = {ctrl_r[tsic_pkg::TIE_BIT], ctrl_r[tsic_pkg::XIE_BIT],
                    ctrl_r[tsic_pkg::CIE_BIT]};
  assign pend    = ctrl_r[tsic_pkg::GIE_BIT] & (|(flags & enables));
  assign pop_req = core_req.pop | core_req.ret_irq;
  // A pop in the same clock wins; the vector waits one instruction cycle
  assign take    = icyc_r & pend & (lat_r == tsic_pkg::LAT_TAKE) & ~supp_r & ~pop_req;
  assign push_req = take | core_req.push;

  // Instruction or bus write cleared the global enable while it was set
  logic gie_drop;
  assign gie_drop = ctrl_r[tsic_pkg::GIE_BIT] &
                    (core_req.gie_clr | (wr_ctrl & ~hwdata[tsic_pkg::GIE_BIT]));

  // Control register: hardware set wins over a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= tsic_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r[tsic_pkg::TIE_BIT] <= hwdata[tsic_pkg::TIE_BIT];
        ctrl_r[tsic_pkg::XIE_BIT] <= hwdata[tsic_pkg::XIE_BIT];
        ctrl_r[tsic_pkg::CIE_BIT] <= hwdata[tsic_pkg::CIE_BIT];
      end
      // Flags set regardless of any enable; only a write clears them
      ctrl_r[tsic_pkg::TIF_BIT] <= tmr_evt |
        (wr_ctrl ? hwdata[tsic_pkg::TIF_BIT] : ctrl_r[tsic_pkg::TIF_BIT]);
      ctrl_r[tsic_pkg::XIF_BIT] <= ext_evt |
        (wr_ctrl ? hwdata[tsic_pkg::XIF_BIT] : ctrl_r[tsic_pkg::XIF_BIT]);
      ctrl_r[tsic_pkg::CIF_BIT] <= chg_evt |
        (wr_ctrl ? hwdata[tsic_pkg::CIF_BIT] : ctrl_r[tsic_pkg::CIF_BIT]);
      // Global enable: vector clears, return sets, else instruction or bus
      if (take) begin
        ctrl_r[tsic_pkg::GIE_BIT] <= 1'b0;
      end else if (core_req.ret_irq) begin
        ctrl_r[tsic_pkg::GIE_BIT] <= 1'b1;
      end else if (core_req.gie_clr) begin
        ctrl_r[tsic_pkg::GIE_BIT] <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl_r[tsic_pkg::GIE_BIT] <= hwdata[tsic_pkg::GIE_BIT];
      end
      ctrl_r[6] <= 1'b0;
    end
  end

  // Latency pipe counts instruction boundaries with the request standing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat_r <= 2'h0;
    end else if (take || !pend || supp_r) begin
      lat_r <= 2'h0;                                                   // stays pending in flags
    end else if (icyc_r && lat_r != tsic_pkg::LAT_TAKE) begin
      lat_r <= 2'(lat_r + 2'h1);
    end
  end

  // One no-operation cycle after the global enable is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supp_r <= 1'b0;
    end else if (gie_drop) begin
      supp_r <= 1'b1;
    end else if (icyc_r) begin
      supp_r <= 1'b0;
    end
  end

  // Circular return stack, no overflow indication by design
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_r <= 3'h0;
    end else if (push_req) begin
      sp_r <= stk_step(sp_r, 1'b1);
    end else if (pop_req) begin
      sp_r <= stk_step(sp_r, 1'b0);
    end
  end

  // Stack storage, written at the pointer; ninth push lands on the oldest
  always_ff @(posedge hclk) begin
    if (push_req) begin
      stack_r[sp_r] <= core_req.pc;
    end
  end

  // Answers to the core; the upper counter latch lives in the core untouched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_r <= '0;
    end else begin
      resp_r.vec_take <= take;
      resp_r.pc_load  <= take | pop_req;
      if (take) begin
        resp_r.pc_val <= tsic_pkg::VECTOR_ADDR;
      end else if (pop_req) begin
        resp_r.pc_val <= stack_r[stk_step(sp_r, 1'b0)];
      end
    end
  end
  always_comb begin
    core_resp              = resp_r;
    core_resp.no_operation = supp_r;
  end

  // AHB-Lite slave: zero wait states, always OKAY
  logic ap_valid;
  logic [31:0] rd_mux;
  assign ap_valid = hsel & htrans[1] & hready;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr)
      tsic_pkg::ADDR_CTRL: rd_mux = {24'h00_0000, ctrl_r & tsic_pkg::CTRL_MASK};
      tsic_pkg::ADDR_TMR:  rd_mux = {24'h00_0000, tmr_r};
      tsic_pkg::ADDR_STAT: rd_mux = {27'h000_0000, supp_r, pend, sp_r};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // Address phase capture; read data sampled here, so it is a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0000_0000;
      hrdata_r  <= 32'h0000_0000;
    end else if (hready) begin
      wr_pend_r <= ap_valid & hwrite & (hsize == tsic_pkg::HSIZE_WORD);
      wr_addr_r <= haddr;
      if (ap_valid && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence vec_seq;
    take ##1 resp_r.vec_take;
  endsequence
  sequence drop_seq;
    gie_drop && !take && !core_req.ret_irq;
  endsequence

  vec_clears_gie_a: assert property (vec_seq |-> !ctrl_r[tsic_pkg::GIE_BIT])
    else $error("global enable still set after vector");
  vec_address_a: assert property (take |=> resp_r.pc_load && resp_r.pc_val == 13'h0004)
    else $error("vector did not load 0004h");
  vec_push_a: assert property (take |=> sp_r == 3'($past(sp_r) + 3'h1)
                               && stack_r[$past(sp_r)] == $past(core_req.pc))
    else $error("return address not pushed");
  gie_gate_a: assert property (!ctrl_r[tsic_pkg::GIE_BIT] |-> !take)
    else $error("vector taken with global enable clear");
  mask_gate_a: assert property (take |-> |(flags & enables))
    else $error("vector taken from masked source");
  flag_sticky_a: assert property ($fell(ctrl_r[tsic_pkg::XIF_BIT]) |-> $past(wr_ctrl))
    else $error("flag cleared without software write");
  ext_flag_a: assert property (ext_evt |=> ctrl_r[tsic_pkg::XIF_BIT])
    else $error("pin edge did not set its flag");
  tmr_wrap_a: assert property (tmr_evt |=> tmr_r == 8'h00 && ctrl_r[tsic_pkg::TIF_BIT])
    else $error("timer wrap did not set its flag");
  ret_gie_a: assert property (core_req.ret_irq && !take |=> ctrl_r[tsic_pkg::GIE_BIT] && resp_r.pc_load)
    else $error("return did not restore global enable");
  drop_nop_a: assert property (drop_seq |=> supp_r && !take)
    else $error("no no-operation after global enable drop");
  lat_bound_a: assert property (pend && icyc_r && lat_r == 2'h0 && !supp_r && !pop_req
                                |-> ##[1:12] (take || !pend || supp_r || pop_req))
    else $error("vector later than latency bound");
  tick_period_a: assert property (icyc_r |=> !icyc_r ##1 !icyc_r ##1 !icyc_r ##1 icyc_r)
    else $error("instruction cycle tick not every four clocks");
  pop_value_a: assert property (pop_req && !take && !core_req.push
                                |=> resp_r.pc_load && resp_r.pc_val == $past(stack_r[stk_step(sp_r, 1'b0)]))
    else $error("return did not load the top stack entry");
  chg_flag_a: assert property (chg_evt |=> ctrl_r[tsic_pkg::CIF_BIT])
    else $error("port change did not set its flag");
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave inserted a wait or an error");

endmodule : tsic_top

`default_nettype wire

// [test/three_source_interrupt_control_tb.sv]
// Self-checking bench for the three-source interrupt control block
`timescale 1ns/100ps
`default_nettype none

module three_source_interrupt_control_tb;
  logic                      hclk              = 1'b0;
  logic                      hresetn           = 1'b0;
  logic                      hsel              = 1'b0;
  logic [31:0]               haddr             = 32'h0000_0000;
  logic [1:0]                htrans            = 2'h0;
  logic                      hwrite            = 1'b0;
  logic [2:0]                hsize             = 3'h0;
  logic [31:0]               hwdata            = 32'h0000_0000;
  logic                      ext_irq_pin       = 1'b0;
  logic [3:0]                change_watch_pins = 4'h0;
  logic                      upper_port_read   = 1'b0;
  logic                      hreadyout;
  logic                      hresp;
  logic [31:0]               hrdata;
  tsic_pkg::tsic_core_req_t  core_req;
  tsic_pkg::tsic_core_resp_t core_resp;
  wire logic                 hready;
  int                        n_errors = 0;
  int                        checked  = 0;
  int                        n_vec    = 0;
  int                        lat;
  logic [31:0]               rd;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;

  tsic_top tsic_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_irq_pin(ext_irq_pin),
    .change_watch_pins(change_watch_pins), .upper_port_read(upper_port_read),
    .core_req(core_req), .core_resp(core_resp), .icyc_tick());

  tsic_core_model tsic_core_model_inst (.hclk(hclk), .hresetn(hresetn),
    .core_resp(core_resp), .core_req(core_req));

  // Vector pulses seen by the core
  always @(posedge hclk) begin
    if (core_resp.vec_take === 1'b1) begin
      n_vec++;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got,
                     input logic [31:0] mask);
    checked++;
    if ((got & mask) !== (exp & mask)) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp & mask, got & mask);
    end
  endtask : chk

  // One AHB single transfer; waits on ready at both phases, data taken at the last edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= tsic_pkg::HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp}, 32'h0000_0001);
  endtask : bus

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp,
                       input logic [31:0] mask);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd, mask);
  endtask : rdchk

  // Bounded wait for a counter load from the block
  task automatic wait_load();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (core_resp.pc_load !== 1'b1 && n < 20);
  endtask : wait_load

  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard, far beyond the few hundred clocks the sequence needs
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    report_and_stop();
  end

  // Main sequence; ctrl reads mask the free-running timer flag except in the reset check and the timer test
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("ctrl", tsic_pkg::ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rdchk("stat", tsic_pkg::ADDR_STAT, 32'h0000_0000, 32'h0000_0007);
    rdchk("unmapped", 32'h0000_000C, 32'h0000_0000, 32'hFFFF_FFFF);
    // Timer wrap sets its flag with every enable clear
    bus(1'b1, tsic_pkg::ADDR_CTRL, 32'h0000_0000);
    bus(1'b1, tsic_pkg::ADDR_TMR, 32'h0000_00FE);
    rdchk("tmr", tsic_pkg::ADDR_TMR, 32'h0000_00FE, 32'h0000_00FF);
    repeat (32) @(posedge hclk);
    rdchk("timer flag", tsic_pkg::ADDR_CTRL, 32'h0000_0004, 32'h0000_0004);
    // Pin flag sets while masked and never clears by itself
    ext_irq_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    ext_irq_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    rdchk("pin flag", tsic_pkg::ADDR_CTRL, 32'h0000_0002, 32'h0000_00FB);
    repeat (40) @(posedge hclk);
    rdchk("pin flag held", tsic_pkg::ADDR_CTRL, 32'h0000_0002, 32'h0000_00FB);
    // Port change against the latch, then the latch catches up
    change_watch_pins <= 4'hA;
    repeat (6) @(posedge hclk);
    rdchk("change flag", tsic_pkg::ADDR_CTRL, 32'h0000_0001, 32'h0000_0001);
    upper_port_read <= 1'b1;
    @(posedge hclk);
    upper_port_read <= 1'b0;
    bus(1'b1, tsic_pkg::ADDR_CTRL, 32'h0000_0000);
    rdchk("change cleared", tsic_pkg::ADDR_CTRL, 32'h0000_0000, 32'h0000_00FB);
    // Flag and enable without global enable, then global without enable: no vector
    bus(1'b1, tsic_pkg::ADDR_CTRL, 32'h0000_0012);
    repeat (24) @(posedge hclk);
    chk("vectors", 32'h0, 32'(n_vec), 32'hFFFF_FFFF);
    bus(1'b1, tsic_pkg::ADDR_CTRL, 32'h0000_0082);
    repeat (24) @(posedge hclk);
    chk("vectors", 32'h0, 32'(n_vec), 32'hFFFF_FFFF);
    // Enabled pin event vectors within three to four instruction cycles
    tsic_core_model_inst.op(4'h0, 13'h1ABC);
    bus(1'b1, tsic_pkg::ADDR_CTRL, 32'h0000_0090);
    @(posedge hclk);
    ext_irq_pin <= 1'b1;
    lat = 0;
    do begin
      @(posedge hclk);
      lat++;
    end while (core_resp.vec_take !== 1'b1 && lat < 40);
    chk("vector pc", 32'h0000_0004, {19'h0, core_resp.pc_val}, 32'h0000_1FFF);
    chk("latency ok", 32'h1, {31'h0, lat >= 10 && lat <= 17}, 32'h1);
    ext_irq_pin <= 1'b0;
    rdchk("ctrl after take", tsic_pkg::ADDR_CTRL, 32'h0000_0012, 32'h0000_00FB);
    rdchk("stack depth", tsic_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_0007);
    // Return pops the address and re-enables globally
    bus(1'b1, tsic_pkg::ADDR_CTRL, 32'h0000_0010);
    tsic_core_model_inst.op(4'b0010, 13'h0000);
    wait_load();
    chk("return pc", 32'h0000_1ABC, {19'h0, core_resp.pc_val}, 32'h0000_1FFF);
    rdchk("ctrl after return", tsic_pkg::ADDR_CTRL, 32'h0000_0090, 32'h0000_00FB);
    // Core clears the global enable: one no-operation follows
    tsic_core_model_inst.op(4'b0001, 13'h0000);
    lat = 0;
    while (core_resp.no_operation !== 1'b1 && lat < 4) begin
      @(posedge hclk);
      lat++;
    end
    chk("no_operation", 32'h1, {31'h0, core_resp.no_operation}, 32'h1);
    rdchk("ctrl after clear", tsic_pkg::ADDR_CTRL, 32'h0000_0010, 32'h0000_00FB);
    // Nine pushes wrap the eight-deep stack without any overflow mark
    bus(1'b1, tsic_pkg::ADDR_CTRL, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      tsic_core_model_inst.op(4'b1000, 13'h0100 + 13'(i));
    end
    rdchk("stack wrap", tsic_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_001F);
    for (int k = 0; k < 8; k++) begin
      tsic_core_model_inst.op(4'b0100, 13'h0000);
      wait_load();
      chk("pop", 32'h0000_0108 - 32'(k), {19'h0, core_resp.pc_val}, 32'h0000_1FFF);
    end
    report_and_stop();
  end
endmodule : three_source_interrupt_control_tb

`default_nettype wire

// [test/tsic_core_model.sv]
// Behavioural model of the core sequencer facing the interrupt control block
`timescale 1ns/100ps
`default_nettype none

module tsic_core_model (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire tsic_pkg::tsic_core_resp_t core_resp,
  output tsic_pkg::tsic_core_req_t       core_req
);
  logic [12:0] cur_pc  = 13'h0000;
  logic [3:0]  strobes = 4'h0;

  // Strobe order: push, pop, return-from-irq, global enable clear
  assign core_req = '{push: strobes[3], pop: strobes[2], ret_irq: strobes[1],
                      gie_clr: strobes[0], pc: cur_pc};

  // The core follows every counter load, so a push always carries its live address
  always @(posedge hclk) begin
    if (hresetn && core_resp.pc_load === 1'b1) begin
      cur_pc <= core_resp.pc_val;
    end
  end

  // One-clock strobe; the following edge is left free so pulses never merge
  task automatic op(input logic [3:0] kind, input logic [12:0] addr);
    @(posedge hclk);
    cur_pc  <= addr;
    strobes <= kind;
    @(posedge hclk);
    strobes <= 4'h0;
  endtask : op
endmodule : tsic_core_model

`default_nettype wire
